// >>> dcm_pkg.sv
// Constants and types for the device config and diagnostic mirror bank
package dcm_pkg;

  // -----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // -----------------------------------------------------------------
  localparam logic [7:0] IDX_DEV_CFG2 = 8'h1B;
  localparam logic [7:0] IDX_BAL_DIAG1 = 8'h1C;
  localparam logic [7:0] IDX_DCHG_CFG = 8'h1D;
  localparam logic [7:0] IDX_MEAS_EN = 8'h1E;
  localparam logic [7:0] IDX_INPUT_CFG = 8'h1F;

  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int B_LOOP = 15;
  localparam int B_DBLBUF = 12;
  localparam int B_LTX_HIZ = 11;
  localparam int B_UTX_HIZ = 10;
  localparam int B_RSVD9 = 9;
  localparam int B_EMRG = 8;
  localparam int B_PUMP_DIS = 0;
  localparam int B_ALTMUX_M = 13;
  localparam int B_POL_M = 12;
  localparam int B_INP_ALTMUX = 0;
  localparam int B_INP_POL = 1;
  localparam int B_WIN_LO = 13;
  localparam int B_CNT_LO = 8;
  localparam int NUM_CELLS = 12;

  // -----------------------------------------------------------------
  // Reset values
  // -----------------------------------------------------------------
  localparam logic [15:0] RST_DEV_CFG2 = 16'h0000;
  localparam logic [11:0] RST_CELLS = 12'h000;
  localparam logic [2:0] RST_WIN = 3'h0;

  // -----------------------------------------------------------------
  // Discharge timing
  // -----------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int TICK_MS = 500;
  localparam int DCHG_STEP_MS = 7500;
  localparam int DCHG_PERIOD_MS = 60000;
  localparam int DCHG_TICK_CYCLES = CLK_KHZ * TICK_MS;
  localparam int TICKS_PER_STEP = DCHG_STEP_MS / TICK_MS;
  localparam int TICKS_PER_PERIOD = DCHG_PERIOD_MS / TICK_MS;

  typedef enum logic {PH_EVEN, PH_ODD} dcm_phase_e;

endpackage

// >>> dcm_dchg_seq.sv
// Emergency discharge even/odd cycle sequencer with readable counter
`timescale 1ns/100ps
module dcm_dchg_seq import dcm_pkg::*; #(
  parameter int TICK_CYCLES = DCHG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic [2:0] win,
  // Outputs
  output logic discharge_even,
  output logic discharge_odd,
  output logic [3:0] dchg_counter
);

  typedef struct packed {
    logic [24:0] div;
    logic [6:0] ticks;
    dcm_phase_e phase;
    logic [3:0] cnt;
    logic even;
    logic odd;
  } dcm_seq_s;

  dcm_seq_s st;
  dcm_seq_s next_st;
  logic tick;
  logic on;
  logic [7:0] on_ticks;

  assign tick = (st.div == 25'(TICK_CYCLES - 1));
  assign on_ticks = 8'(({5'h00, win} + 8'h01) * TICKS_PER_STEP);
  assign on = ({1'b0, st.ticks} < on_ticks);

  always_comb begin
    next_st = st;
    if (!enable) begin
      next_st = '0;
    end else begin
      next_st.div = tick ? 25'h0000000 : st.div + 25'h0000001;
      if (tick) begin
        next_st.cnt = st.cnt + 4'h1;
        if (st.ticks == 7'(TICKS_PER_PERIOD - 1)) begin
          next_st.ticks = 7'h00;
          next_st.phase = (st.phase == PH_EVEN) ? PH_ODD : PH_EVEN;
        end else begin
          next_st.ticks = st.ticks + 7'h01;
        end
      end
      next_st.even = on && (st.phase == PH_EVEN);
      next_st.odd = on && (st.phase == PH_ODD);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign discharge_even = st.even;
  assign discharge_odd = st.odd;
  assign dchg_counter = st.cnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dchg_exclusive: assert property (!(discharge_even && discharge_odd))
    else $error("even and odd discharge both on");
  a_dchg_idle: assert property (!enable |=> !discharge_even && !discharge_odd)
    else $error("discharge on while disabled");

endmodule

// >>> dcm_regs.sv
// Device config and diagnostic mirror register bank with APB slave
`timescale 1ns/100ps
module dcm_regs import dcm_pkg::*; #(
  parameter int TICK_CYCLES = DCHG_TICK_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Upper UART port
  input wire logic upper_tx_data,
  input wire logic upper_tx_active,
  input wire logic upper_rx_pin,
  output logic upper_rx_to_core,
  output logic upper_tx_out,
  output logic upper_tx_oe_n,
  // Lower UART port
  input wire logic lower_tx_data,
  input wire logic lower_tx_active,
  output logic lower_tx_out,
  output logic lower_tx_oe_n,
  // Device controls
  output logic upper_port_loopback_en,
  output logic alt_double_buffer_sel,
  output logic lower_tx_idle_highz,
  output logic upper_tx_idle_highz,
  output logic emergency_discharge_en,
  output logic hv_pump_disable,
  output logic alternate_input_route_sel,
  output logic sense_invert,
  output logic [11:0] cell_measure_enables,
  // Emergency discharge
  output logic discharge_even,
  output logic discharge_odd
);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic loop;
    logic dblbuf;
    logic ltx_hiz;
    logic utx_hiz;
    logic rsvd9;
    logic emrg;
    logic pump_dis;
    logic altmux;
    logic pol;
    logic [11:0] cells;
    logic [2:0] win;
    logic [31:0] rdata;
  } dcm_state_s;

  dcm_state_s st;
  dcm_state_s next_st;

  // -----------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdata,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = wdata[15:8];
    end
  endfunction

  logic setup;
  logic access;
  logic mapped;
  logic wr;
  logic wr_cfg2;
  logic wr_diag1;
  logic wr_dchg;
  logic wr_meas;
  logic wr_inp;
  logic [3:0] dchg_counter;
  logic [15:0] rd_cfg2;
  logic [15:0] rd_diag1;
  logic [15:0] rd_dchg;
  logic [15:0] rd_meas;
  logic [15:0] rd_inp;
  logic [15:0] rd_sel;
  logic [15:0] m_cfg2;
  logic [15:0] m_diag1;
  logic [15:0] m_dchg;
  logic [15:0] m_meas;
  logic [15:0] m_inp;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = reg_hit(paddr, IDX_DEV_CFG2) ||
                  reg_hit(paddr, IDX_BAL_DIAG1) ||
                  reg_hit(paddr, IDX_DCHG_CFG) ||
                  reg_hit(paddr, IDX_MEAS_EN) ||
                  reg_hit(paddr, IDX_INPUT_CFG);
  assign wr = access && pwrite;
  assign wr_cfg2 = wr && reg_hit(paddr, IDX_DEV_CFG2);
  assign wr_diag1 = wr && reg_hit(paddr, IDX_BAL_DIAG1);
  assign wr_dchg = wr && reg_hit(paddr, IDX_DCHG_CFG);
  assign wr_meas = wr && reg_hit(paddr, IDX_MEAS_EN);
  assign wr_inp = wr && reg_hit(paddr, IDX_INPUT_CFG);

  // -----------------------------------------------------------------
  // Read views; mirrors read the primary storage
  // -----------------------------------------------------------------
  always_comb begin
    rd_cfg2 = RST_DEV_CFG2;
    rd_cfg2[B_LOOP] = st.loop;
    rd_cfg2[B_DBLBUF] = st.dblbuf;
    rd_cfg2[B_LTX_HIZ] = st.ltx_hiz;
    rd_cfg2[B_UTX_HIZ] = st.utx_hiz;
    rd_cfg2[B_RSVD9] = st.rsvd9;
    rd_cfg2[B_EMRG] = st.emrg;
    rd_cfg2[B_PUMP_DIS] = st.pump_dis;
    rd_diag1 = 16'h0000;
    rd_diag1[B_ALTMUX_M] = st.altmux;
    rd_diag1[B_POL_M] = st.pol;
    rd_diag1[NUM_CELLS-1:0] = st.cells;
    rd_dchg = 16'h0000;
    rd_dchg[B_WIN_LO +: 3] = st.win;
    rd_dchg[B_CNT_LO +: 4] = dchg_counter;
    rd_meas = 16'h0000;
    rd_meas[NUM_CELLS-1:0] = st.cells;
    rd_inp = 16'h0000;
    rd_inp[B_INP_ALTMUX] = st.altmux;
    rd_inp[B_INP_POL] = st.pol;
  end

  always_comb begin
    rd_sel = 16'h0000;
    if (reg_hit(paddr, IDX_DEV_CFG2)) begin
      rd_sel = rd_cfg2;
    end else if (reg_hit(paddr, IDX_BAL_DIAG1)) begin
      rd_sel = rd_diag1;
    end else if (reg_hit(paddr, IDX_DCHG_CFG)) begin
      rd_sel = rd_dchg;
    end else if (reg_hit(paddr, IDX_MEAS_EN)) begin
      rd_sel = rd_meas;
    end else if (reg_hit(paddr, IDX_INPUT_CFG)) begin
      rd_sel = rd_inp;
    end
  end

  assign m_cfg2 = merge16(rd_cfg2, pwdata, pstrb);
  assign m_diag1 = merge16(rd_diag1, pwdata, pstrb);
  assign m_dchg = merge16(rd_dchg, pwdata, pstrb);
  assign m_meas = merge16(rd_meas, pwdata, pstrb);
  assign m_inp = merge16(rd_inp, pwdata, pstrb);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Loaded in setup so it stands through the access phase
    if (setup) begin
      next_st.rdata = {16'h0000, rd_sel};
    end
    // Unmapped writes match no decode and change nothing
    if (wr_cfg2) begin
      next_st.loop = m_cfg2[B_LOOP];
      next_st.dblbuf = m_cfg2[B_DBLBUF];
      next_st.ltx_hiz = m_cfg2[B_LTX_HIZ];
      next_st.utx_hiz = m_cfg2[B_UTX_HIZ];
      next_st.rsvd9 = m_cfg2[B_RSVD9];
      next_st.emrg = m_cfg2[B_EMRG];
      next_st.pump_dis = m_cfg2[B_PUMP_DIS];
    end
    // Single storage behind both the mirror and the primary
    if (wr_diag1) begin
      next_st.altmux = m_diag1[B_ALTMUX_M];
      next_st.pol = m_diag1[B_POL_M];
      next_st.cells = m_diag1[NUM_CELLS-1:0];
    end
    if (wr_meas) begin
      next_st.cells = m_meas[NUM_CELLS-1:0];
    end
    if (wr_inp) begin
      next_st.altmux = m_inp[B_INP_ALTMUX];
      next_st.pol = m_inp[B_INP_POL];
    end
    if (wr_dchg) begin
      next_st.win = m_dchg[B_WIN_LO +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------
  // Emergency discharge sequencer
  // -----------------------------------------------------------------
  dcm_dchg_seq #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .enable(st.emrg),
    .win(st.win),
    .discharge_even(discharge_even),
    .discharge_odd(discharge_odd),
    .dchg_counter(dchg_counter)
  );

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  assign upper_port_loopback_en = st.loop;
  assign alt_double_buffer_sel = st.dblbuf;
  assign lower_tx_idle_highz = st.ltx_hiz;
  assign upper_tx_idle_highz = st.utx_hiz;
  assign emergency_discharge_en = st.emrg;
  assign hv_pump_disable = st.pump_dis;
  assign alternate_input_route_sel = st.altmux;
  assign sense_invert = st.pol;
  assign cell_measure_enables = st.cells;

  // Internal loopback of the upper port
  assign upper_rx_to_core = st.loop ? upper_tx_data : upper_rx_pin;

  // Idle drivers: low by default, floated in high-Z idle mode
  assign lower_tx_out = lower_tx_active ? lower_tx_data : 1'b0;
  assign lower_tx_oe_n = !lower_tx_active && st.ltx_hiz;
  assign upper_tx_out = upper_tx_active ? upper_tx_data : 1'b0;
  assign upper_tx_oe_n = !upper_tx_active && st.utx_hiz;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_loop_route: assert property (
    upper_port_loopback_en |-> upper_rx_to_core == upper_tx_data)
    else $error("loopback not routing upper transmitter");

  a_dblbuf_write: assert property (
    wr_cfg2 && pstrb[1] |=> alt_double_buffer_sel == $past(pwdata[B_DBLBUF]))
    else $error("double buffer select not written");

  a_lower_idle: assert property (
    !lower_tx_active |-> lower_tx_oe_n == lower_tx_idle_highz &&
                          lower_tx_out == 1'b0)
    else $error("lower transmitter idle state wrong");

  a_upper_idle: assert property (
    !upper_tx_active |-> upper_tx_oe_n == upper_tx_idle_highz &&
                          upper_tx_out == 1'b0)
    else $error("upper transmitter idle state wrong");

  a_rsvd_store: assert property (
    wr_cfg2 && pstrb[1] |=> rd_cfg2[B_RSVD9] == $past(pwdata[B_RSVD9]))
    else $error("storage bit nine lost written value");

  a_emrg_start: assert property (
    wr_cfg2 && pstrb[1] && pwdata[B_EMRG] && !emergency_discharge_en |=>
    emergency_discharge_en ##1 (discharge_even || discharge_odd))
    else $error("emergency discharge did not start");

  a_pump_write: assert property (
    wr_cfg2 && pstrb[0] |=> hv_pump_disable == $past(pwdata[B_PUMP_DIS]))
    else $error("charge pump disable not written");

  a_mux_alias: assert property (
    wr_diag1 && pstrb[1] |=>
    alternate_input_route_sel == $past(pwdata[B_ALTMUX_M]))
    else $error("alternate mux mirror not aliased");

  a_pol_alias: assert property (
    wr_diag1 && pstrb[1] |=> sense_invert == $past(pwdata[B_POL_M]))
    else $error("polarity mirror not aliased");

  a_cell_write: assert property (
    wr_diag1 && pstrb[1:0] == 2'b11 |=>
    cell_measure_enables == $past(pwdata[11:0]))
    else $error("cell mirror write missed enables");

  a_cell_read: assert property (
    setup && !pwrite && reg_hit(paddr, IDX_BAL_DIAG1) |=>
    prdata[11:0] == $past(cell_measure_enables))
    else $error("cell mirror read mismatch");

  a_shared_store: assert property (
    wr_meas && pstrb[1:0] == 2'b11 |=> rd_diag1[11:0] == $past(pwdata[11:0]))
    else $error("primary write not visible through mirror");

  a_hiz_store: assert property (
    wr_cfg2 && pstrb[1] |=>
    lower_tx_idle_highz == $past(pwdata[B_LTX_HIZ]) &&
    upper_tx_idle_highz == $past(pwdata[B_UTX_HIZ]))
    else $error("idle high-Z bits not stored");

  a_inp_alias: assert property (
    wr_inp && pstrb[0] |=>
    alternate_input_route_sel == $past(pwdata[B_INP_ALTMUX]) &&
    sense_invert == $past(pwdata[B_INP_POL]))
    else $error("primary write not visible on controls");

  a_unmapped_read: assert property (
    setup && !mapped |=> prdata == 32'h00000000)
    else $error("unmapped read returned data");

  a_rdata_upper: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data half not zero");

  a_unmapped_err: assert property (
    access && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");

  c_loopback: cover property (wr_cfg2 && pwdata[B_LOOP] ##1
                              upper_port_loopback_en);
  c_mirror_write: cover property (wr_diag1 ##1 setup && !pwrite);
  c_discharge: cover property (emergency_discharge_en && discharge_even);
  c_unmapped: cover property (pslverr);
  c_odd_phase: cover property (emergency_discharge_en && discharge_odd);

endmodule

// >>> dcm_host.sv
// Host side APB master model driving the register bank
`timescale 1ns/100ps
module dcm_host import dcm_pkg::*; (
  // Clock
  input wire logic pclk,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
  end

  // ---------------------------------------------------------------
  // One transfer: setup, then access until pready
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [15:0] wd, input logic [3:0] st,
                      output logic [15:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {~wd, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= {wd, ~wd};
  endtask
endmodule

// >>> dcm_regs_tb.sv
// Self-checking testbench for the config and mirror register bank
`timescale 1ns/100ps
module dcm_regs_tb import dcm_pkg::*;;
  localparam int TICKS = 4;
  typedef struct {
    logic [7:0] widx;
    logic [15:0] wd;
    logic [7:0] ridx;
    logic [15:0] rexp;
  } dcm_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic utd, uta, urp, urc, uto, uton, ltd, lta, lto, lton;
  logic loop_en, dbl, lhz, uhz, emrg, pump, altmux, sinv, dev, dodd;
  logic [11:0] cells;
  logic [15:0] r;
  logic e;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  dcm_row_s rows[7] = '{
    '{8'h1B, 16'hFFFF, 8'h1B, 16'h9F01},
    '{8'h1B, 16'h0200, 8'h1B, 16'h0200},
    '{8'h1C, 16'hFFFF, 8'h1E, 16'h0FFF},
    '{8'h1E, 16'h0A5C, 8'h1C, 16'h3A5C},
    '{8'h1F, 16'h0001, 8'h1C, 16'h2A5C},
    '{8'h1C, 16'h0000, 8'h1F, 16'h0000},
    '{8'h1C, 16'h3123, 8'h1E, 16'h0123}
  };

  always #12.5 pclk = ~pclk;

  dcm_regs #(.TICK_CYCLES(TICKS)) dcm_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .upper_tx_data(utd), .upper_tx_active(uta), .upper_rx_pin(urp),
    .upper_rx_to_core(urc), .upper_tx_out(uto), .upper_tx_oe_n(uton),
    .lower_tx_data(ltd), .lower_tx_active(lta), .lower_tx_out(lto),
    .lower_tx_oe_n(lton), .upper_port_loopback_en(loop_en),
    .alt_double_buffer_sel(dbl), .lower_tx_idle_highz(lhz),
    .upper_tx_idle_highz(uhz), .emergency_discharge_en(emrg),
    .hv_pump_disable(pump), .alternate_input_route_sel(altmux),
    .sense_invert(sinv), .cell_measure_enables(cells),
    .discharge_even(dev), .discharge_odd(dodd)
  );

  dcm_host dcm_host_inst (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg,
               got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] wd,
                    input logic [3:0] st);
    dcm_host_inst.xfer(1'b1, idx, wd, st, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    dcm_host_inst.xfer(1'b0, idx, 16'h0000, 4'h0, r, e);
    chk(r, exp, "read data");
  endtask

  task automatic pins(input logic [4:0] v, input logic [4:0] exp);
    @(posedge pclk);
    {utd, uta, urp, ltd, lta} <= v;
    #1;
    chk({11'h000, urc, uto, uton, lto, lton}, {11'h000, exp}, "pins");
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(25 * 6000);
    mismatches++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {utd, uta, urp, ltd, lta} = 5'h00;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(IDX_DEV_CFG2, RST_DEV_CFG2);
    rd_chk(IDX_BAL_DIAG1, 16'h0000);
    chk({8'h00, loop_en, dbl, lhz, uhz, emrg, pump, altmux, sinv}, 16'h0000,
        "reset controls");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].widx, rows[i].wd, 4'hF);
      rd_chk(rows[i].ridx, rows[i].rexp);
    end
    #1;
    chk({2'b00, altmux, sinv, cells}, 16'h3123, "mirror outputs");
    $display("test table done");
    wr(IDX_DEV_CFG2, 16'h0000, 4'hF);
    wr(IDX_DEV_CFG2, 16'hFFFF, 4'h1);
    rd_chk(IDX_DEV_CFG2, 16'h0001);
    wr(IDX_DEV_CFG2, 16'hFFFF, 4'h2);
    rd_chk(IDX_DEV_CFG2, 16'h9F01);
    chk({10'h000, loop_en, dbl, lhz, uhz, emrg, pump}, 16'h003F,
        "controls");
    dcm_host_inst.xfer(1'b0, 8'h10, 16'h0000, 4'h0, r, e);
    chk({e, r[14:0]}, 16'h8000, "unmapped read");
    $display("test strobe and unmapped done");
    wr(IDX_DEV_CFG2, 16'h8C00, 4'hF);
    pins(5'b10000, 5'b10101);
    pins(5'b00100, 5'b00101);
    pins(5'b11011, 5'b11010);
    wr(IDX_DEV_CFG2, 16'h0000, 4'hF);
    pins(5'b10000, 5'b00000);
    $display("test uart pins done");
    wr(IDX_DCHG_CFG, 16'h2000, 4'hF);
    rd_chk(IDX_DCHG_CFG, 16'h2000);
    wr(IDX_DEV_CFG2, 16'h0100, 4'hF);
    n = 0;
    while (dev !== 1'b1 && n < 20) begin
      @(negedge pclk);
      n++;
    end
    chk({15'h0000, dev}, 16'h0001, "even start");
    n = 0;
    while (dev === 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
      if (dodd === 1'b1)
        chk(16'h0001, 16'h0000, "both phases on");
    end
    chk(n[15:0], 16'(2 * TICKS_PER_STEP * TICKS), "on time");
    n = 0;
    while (dodd !== 1'b1 && n < 600) begin
      @(negedge pclk);
      n++;
    end
    chk({15'h0000, dodd}, 16'h0001, "odd phase");
    wr(IDX_DEV_CFG2, 16'h0000, 4'hF);
    repeat (3) @(negedge pclk);
    chk({14'h0000, dev, dodd}, 16'h0000, "discharge off");
    $display("test discharge done");
    wr(IDX_DEV_CFG2, 16'hFFFF, 4'hF);
    wr(IDX_BAL_DIAG1, 16'hFFFF, 4'hF);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({14'h0000, dev, dodd}, 16'h0000, "reset discharge");
    rd_chk(IDX_DEV_CFG2, RST_DEV_CFG2);
    rd_chk(IDX_BAL_DIAG1, 16'h0000);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
